// >>> verilog/wwdt_top.v
// Windowed watchdog timer with AXI4-Lite register access
//
// Notes on behaviour
// RL1 - Zero count without valid refresh forces a processor reset.
// RL2 - Writing key 0xcccc to the refresh register is a valid refresh.
// RL3 - Any other refresh value forces a watchdog reset at once.
// RL4 - Counter halts in reset, debug, and hibernate when so selected.
// RL5 - Timeout counter is a 16-bit down-counter behind a prescaler.
// RL6 - Prescaler divides the source by 1, 16, 256 or 4096.
// RL7 - Control bit 8 selects the oscillator halved instead of undivided.
// RL8 - Reset restores defaults; software may change them while disabled.
// RL9 - Once enabled, configuration and enable writes are ignored until reset.
// RL10 - Reaching zero gives a timeout: a reset unless interrupt mode is chosen.
// RL11 - Valid refresh reloads from the load value and counting restarts at once.
// RL12 - Reset output logic runs from the slow-clock tick path and from refresh-register writes.
// RL13 - With control bit 9 set, refresh at or above the minimum load is a violation.
// RL14 - Debug mode turns timeouts and violations into an interrupt, not a reset.
// RL15 - In interrupt mode control bit 0 has no effect.
// RL16 - Software disables before debugging; reset mode in production.
// RL17 - Count register returns the live 16-bit counter, read only.
// RL18 - Load register holds the start value; resets to 0x1000.
// RL19 - Bit 6 picks free-running (wrap at 0x1000) or periodic (default) counting.
// RL20 - Control bit 1 makes timeouts and early refreshes raise an interrupt.
// RL21 - Control bit 5 enables the timer; clearing it disables. The code locks the bit once set, so only reset clears it.
// RL22 - Bus writes reach the counter safely synchronised.
// RL23 - A rejected refresh gives the same reset or interrupt as a timeout and reloads the count.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "wwdt_defines.vh"

module wwdt_top (
   // Clock and reset
   input  wire        MCLK_IN,
   input  wire        RST_N_IN,
   // Low-frequency oscillator pin
   input  wire        LFOSC_IN,
   // System state
   input  wire        DEBUG_HALT_IN,
   input  wire        HIBERNATE_IN,
   // AXI4-Lite write address
   input  wire [31:0] S_AXI_AWADDR_IN,
   input  wire [2:0]  S_AXI_AWPROT_IN,
   input  wire        S_AXI_AWVALID_IN,
   output wire        S_AXI_AWREADY_OUT,
   // AXI4-Lite write data
   input  wire [31:0] S_AXI_WDATA_IN,
   input  wire [3:0]  S_AXI_WSTRB_IN,
   input  wire        S_AXI_WVALID_IN,
   output wire        S_AXI_WREADY_OUT,
   // AXI4-Lite write response
   output wire [1:0]  S_AXI_BRESP_OUT,
   output wire        S_AXI_BVALID_OUT,
   input  wire        S_AXI_BREADY_IN,
   // AXI4-Lite read address
   input  wire [31:0] S_AXI_ARADDR_IN,
   input  wire [2:0]  S_AXI_ARPROT_IN,
   input  wire        S_AXI_ARVALID_IN,
   output wire        S_AXI_ARREADY_OUT,
   // AXI4-Lite read data
   output wire [31:0] S_AXI_RDATA_OUT,
   output wire [1:0]  S_AXI_RRESP_OUT,
   output wire        S_AXI_RVALID_OUT,
   input  wire        S_AXI_RREADY_IN,
   // Watchdog outcomes
   output wire        WDT_RESET_REQ_OUT,
   output wire        WDT_IRQ_OUT
);

   // ==========================================
   // Declarations
   reg  [15:0] load_ff;
   reg  [15:0] minload_ff;
   reg  [15:0] ctrl_ff;
   reg  [15:0] count_ff;
   reg  [15:0] nxt_count;
   reg  [4:0]  sticky_ff;
   reg         irq_ff;
   reg         rst_req_ff;
   reg         aw_held_ff;
   reg  [31:0] aw_addr_ff;
   reg         w_held_ff;
   reg  [31:0] w_data_ff;
   reg  [3:0]  w_strb_ff;
   reg         bvalid_ff;
   reg  [1:0]  bresp_ff;
   reg         rvalid_ff;
   reg  [31:0] rdata_ff;
   reg  [1:0]  rresp_ff;
   reg         ev_timeout;
   reg         ev_early;
   reg         ev_badkey;
   reg         ev_refresh;
   wire        wr_go;
   wire        rd_go;
   wire [15:0] wr_val;
   wire        wr_load;
   wire        wr_ctrl;
   wire        wr_refresh;
   wire        wr_minload;
   wire        wr_known;
   wire        locked;
   wire        irq_mode;
   wire        halted;
   wire        running;
   wire        tick;
   wire        violation;
   wire [15:0] ctrl_view;

   // ==========================================
   // Helper functions
   function addr_hit;
      input [31:0] addr;
      input [31:0] reg_addr;
      begin
         addr_hit = ({addr[31:2], 2'b00} == reg_addr);
      end
   endfunction

   function [15:0] merge_lanes;
      input [15:0] old_val;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge_lanes[7:0]  = strb[0] ? data[7:0]  : old_val[7:0];
         merge_lanes[15:8] = strb[1] ? data[15:8] : old_val[15:8];
      end
   endfunction

   // ==========================================
   // Mode decode
   assign locked    = ctrl_ff[`WWDT_CTRL_EN]; // RL9
   assign irq_mode  = ctrl_ff[`WWDT_CTRL_DBGIRQ] | ctrl_ff[`WWDT_CTRL_IRQ]; // RL14 RL20
   // Hibernate stop bit ignored in interrupt mode
   assign halted    = DEBUG_HALT_IN | (HIBERNATE_IN & ctrl_ff[`WWDT_CTRL_PDHALT] & !irq_mode); // RL4 RL15
   assign running   = ctrl_ff[`WWDT_CTRL_EN] & !halted; // RL21
   assign ctrl_view = ctrl_ff | `WWDT_CTRL_FIXED_ONES;

   // ==========================================
   // Slow-clock step generator
   wwdt_prescaler i_wwdt_prescaler (
      .clk_in       (MCLK_IN),
      .rst_n_in     (RST_N_IN),
      .osc_in       (LFOSC_IN),
      .halve_in     (ctrl_ff[`WWDT_CTRL_HALVE]),
      .presc_sel_in (ctrl_ff[`WWDT_CTRL_PRE_HI:`WWDT_CTRL_PRE_LO]),
      .run_in       (running),
      .tick_out     (tick)
   );

   // ==========================================
   // AXI4-Lite write channels
   // Address and data parked apart; write acts once both are in
   assign S_AXI_AWREADY_OUT = !aw_held_ff && !bvalid_ff;
   assign S_AXI_WREADY_OUT  = !w_held_ff && !bvalid_ff;
   assign S_AXI_BVALID_OUT  = bvalid_ff;
   assign S_AXI_BRESP_OUT   = bresp_ff;
   assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;

   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= 32'h00000000;
         w_held_ff  <= 1'b0;
         w_data_ff  <= 32'h00000000;
         w_strb_ff  <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `WWDT_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= S_AXI_AWADDR_IN;
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            w_held_ff <= 1'b1;
            w_data_ff <= S_AXI_WDATA_IN;
            w_strb_ff <= S_AXI_WSTRB_IN;
         end
         if (wr_go) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= wr_known ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
         end else if (bvalid_ff && S_AXI_BREADY_IN) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // Write decode
   assign wr_load    = wr_go && addr_hit(aw_addr_ff, `WWDT_ADDR_LOAD);
   assign wr_ctrl    = wr_go && addr_hit(aw_addr_ff, `WWDT_ADDR_CTRL);
   assign wr_refresh = wr_go && addr_hit(aw_addr_ff, `WWDT_ADDR_REFRESH);
   assign wr_minload = wr_go && addr_hit(aw_addr_ff, `WWDT_ADDR_MINLOAD);
   // Read-only registers take writes silently
   assign wr_known   = wr_load || wr_ctrl || wr_refresh || wr_minload
                       || addr_hit(aw_addr_ff, `WWDT_ADDR_COUNT)
                       || addr_hit(aw_addr_ff, `WWDT_ADDR_STATUS);

   // ==========
   // Configuration, frozen once enabled
   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         load_ff    <= `WWDT_RST_LOAD; // RL8 RL18
         minload_ff <= `WWDT_RST_MINLOAD; // RL8
         ctrl_ff    <= `WWDT_RST_CTRL; // RL8
      end else if (!locked) begin
         if (wr_load) begin
            load_ff <= merge_lanes(load_ff, w_data_ff, w_strb_ff); // RL18
         end
         if (wr_minload) begin
            minload_ff <= merge_lanes(minload_ff, w_data_ff, w_strb_ff);
         end
         if (wr_ctrl) begin
            ctrl_ff <= merge_lanes(ctrl_ff, w_data_ff, w_strb_ff) & `WWDT_CTRL_WMASK; // RL21
         end
      end
   end

   // ==========================================
   // Refresh and violation decode
   // Key judged with unwritten lanes as zero
   assign wr_val    = merge_lanes(16'h0000, w_data_ff, w_strb_ff);
   // Window passed once the count drops below minimum load
   assign violation = ctrl_ff[`WWDT_CTRL_WINDOW] && (count_ff >= minload_ff); // RL13

   always @* begin
      ev_refresh = 1'b0;
      ev_early   = 1'b0;
      ev_badkey  = 1'b0;
      ev_timeout = 1'b0;
      if (wr_refresh) begin
         if (wr_val != `WWDT_REFRESH_KEY) begin
            ev_badkey = 1'b1; // RL3
         end else if (ctrl_ff[`WWDT_CTRL_EN]) begin
            if (violation) begin
               ev_early = 1'b1; // RL13
            end else begin
               ev_refresh = 1'b1; // RL2
            end
         end
      end
      // Refresh in the zero-step cycle still rescues the period
      if (tick && running && (count_ff == 16'h0000) && !ev_refresh) begin
         ev_timeout = 1'b1; // RL1 RL10
      end
   end

   // ==========================================
   // Down-counter
   // RL22: one clock; only the oscillator pin is
   // resynchronised, in the prescaler
   always @* begin
      nxt_count = count_ff;
      if (!ctrl_ff[`WWDT_CTRL_EN]) begin
         nxt_count = load_ff; // Idle count shows its start value
      end else if (ev_refresh) begin
         nxt_count = load_ff; // RL11
      end else if (ev_early || ev_badkey) begin
         nxt_count = load_ff; // RL23
      end else if (tick && running) begin
         if (count_ff == 16'h0000) begin
            if (ctrl_ff[`WWDT_CTRL_MODE]) begin
               nxt_count = load_ff; // RL19
            end else begin
               nxt_count = `WWDT_FREE_WRAP; // RL19
            end
         end else begin
            nxt_count = count_ff - 16'h0001; // RL5
         end
      end
   end

   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         count_ff <= `WWDT_RST_COUNT;
      end else begin
         count_ff <= nxt_count;
      end
   end

   // ==========================================
   // Outcome logic: reset request pulse or interrupt level
   // Fed only by slow-clock steps and refresh events
   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rst_req_ff <= 1'b0;
         irq_ff     <= 1'b0;
      end else begin
         rst_req_ff <= 1'b0;
         if (ev_timeout || ev_early || ev_badkey) begin
            if (irq_mode) begin
               irq_ff <= 1'b1; // RL14 RL20 RL23
            end else begin
               rst_req_ff <= 1'b1; // RL1 RL3 RL10 RL12 RL23
            end
         end else if (ev_refresh) begin
            irq_ff <= 1'b0; // Set wins over clear
         end
      end
   end

   assign WDT_RESET_REQ_OUT = rst_req_ff;
   assign WDT_IRQ_OUT       = irq_ff;

   // ==========================================
   // Status flags, sticky until reset
   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sticky_ff <= 5'h00;
      end else begin
         if (ev_timeout) begin
            sticky_ff[`WWDT_STA_TIMEOUT] <= 1'b1;
         end
         if (ev_early) begin
            sticky_ff[`WWDT_STA_EARLY] <= 1'b1;
         end
         if (ev_badkey) begin
            sticky_ff[`WWDT_STA_BADKEY] <= 1'b1;
         end
      end
   end

   // ==========================================
   // AXI4-Lite read channel
   // One read at a time
   assign S_AXI_ARREADY_OUT = !rvalid_ff;
   assign S_AXI_RVALID_OUT  = rvalid_ff;
   assign S_AXI_RDATA_OUT   = rdata_ff;
   assign S_AXI_RRESP_OUT   = rresp_ff;
   assign rd_go = S_AXI_ARVALID_IN && !rvalid_ff;

   always @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h00000000;
         rresp_ff  <= `WWDT_RESP_OKAY;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= `WWDT_RESP_OKAY;
         if (addr_hit(S_AXI_ARADDR_IN, `WWDT_ADDR_LOAD)) begin
            rdata_ff <= {16'h0000, load_ff};
         end else if (addr_hit(S_AXI_ARADDR_IN, `WWDT_ADDR_COUNT)) begin
            rdata_ff <= {16'h0000, count_ff}; // RL17
         end else if (addr_hit(S_AXI_ARADDR_IN, `WWDT_ADDR_CTRL)) begin
            rdata_ff <= {16'h0000, ctrl_view};
         end else if (addr_hit(S_AXI_ARADDR_IN, `WWDT_ADDR_REFRESH)) begin
            rdata_ff <= 32'h00000000; // Write-only, reads zero
         end else if (addr_hit(S_AXI_ARADDR_IN, `WWDT_ADDR_STATUS)) begin
            rdata_ff <= {27'h0000000, irq_ff, locked, sticky_ff[2:0]};
         end else if (addr_hit(S_AXI_ARADDR_IN, `WWDT_ADDR_MINLOAD)) begin
            rdata_ff <= {16'h0000, minload_ff};
         end else begin
            rdata_ff <= 32'h00000000;
            rresp_ff <= `WWDT_RESP_SLVERR;
         end
      end else if (S_AXI_RREADY_IN) begin
         rvalid_ff <= 1'b0;
      end
   end

endmodule // wwdt_top

// >>> include/wwdt_defines.vh
// Windowed watchdog constants
`ifndef WWDT_DEFINES_VH
`define WWDT_DEFINES_VH

// ==========================================
// Register byte addresses
`define WWDT_ADDR_LOAD        32'h400c0900
`define WWDT_ADDR_COUNT       32'h400c0904
`define WWDT_ADDR_CTRL        32'h400c0908
`define WWDT_ADDR_REFRESH     32'h400c090c
`define WWDT_ADDR_STATUS      32'h400c0918
`define WWDT_ADDR_MINLOAD     32'h400c091c

// ==========================================
// Reset values
`define WWDT_RST_LOAD         16'h1000
`define WWDT_RST_COUNT        16'h1000
`define WWDT_RST_CTRL         16'h00c9
`define WWDT_RST_MINLOAD      16'h0800
`define WWDT_RST_STATUS       16'h0000

// ==========================================
// Control field positions
`define WWDT_CTRL_PDHALT      0
`define WWDT_CTRL_IRQ         1
`define WWDT_CTRL_PRE_LO      2
`define WWDT_CTRL_PRE_HI      3
`define WWDT_CTRL_EN          5
`define WWDT_CTRL_MODE        6
`define WWDT_CTRL_FIXED       7
`define WWDT_CTRL_HALVE       8
`define WWDT_CTRL_WINDOW      9
`define WWDT_CTRL_DBGIRQ      10
`define WWDT_CTRL_WMASK       16'h076f
`define WWDT_CTRL_FIXED_ONES  16'h0080

// ==========================================
// Status field positions
`define WWDT_STA_TIMEOUT      0
`define WWDT_STA_EARLY        1
`define WWDT_STA_BADKEY       2
`define WWDT_STA_LOCKED       3
`define WWDT_STA_IRQ          4

// ==========================================
// Key, wrap value and prescaler limits
`define WWDT_REFRESH_KEY      16'hcccc
`define WWDT_FREE_WRAP        16'h1000
`define WWDT_PRE_LIM_1        12'h000
`define WWDT_PRE_LIM_16       12'h00f
`define WWDT_PRE_LIM_256      12'h0ff
`define WWDT_PRE_LIM_4096     12'hfff

// ==========================================
// Bus answers
`define WWDT_RESP_OKAY        2'b00
`define WWDT_RESP_SLVERR      2'b10

`endif

// >>> verilog/wwdt_prescaler.v
// Oscillator sampling, halving and prescaler
`timescale 1ns/1ns
`include "wwdt_defines.vh"

module wwdt_prescaler (
   // Clock and reset
   input  wire        clk_in,
   input  wire        rst_n_in,
   // Oscillator pin and settings
   input  wire        osc_in,
   input  wire        halve_in,
   input  wire [1:0]  presc_sel_in,
   input  wire        run_in,
   // Counter step enable
   output wire        tick_out
);

   reg        sync1_ff;
   reg        sync2_ff;
   reg        sync3_ff;
   reg        osc_lvl_ff;
   reg        half_ff;
   reg [11:0] pre_cnt_ff;
   reg        tick_ff;
   wire       osc_rise;
   wire       src_edge;
   wire [11:0] limit;

   // ==========
   // Ratio decode
   function [11:0] pre_limit;
      input [1:0] sel;
      begin
         case (sel)
            2'b00:   pre_limit = `WWDT_PRE_LIM_1;
            2'b01:   pre_limit = `WWDT_PRE_LIM_16;
            2'b10:   pre_limit = `WWDT_PRE_LIM_256;
            default: pre_limit = `WWDT_PRE_LIM_4096;
         endcase
      end
   endfunction

   assign limit    = pre_limit(presc_sel_in); // RL6
   assign osc_rise = (sync2_ff == sync3_ff) && sync3_ff && !osc_lvl_ff;
   assign src_edge = osc_rise && (!halve_in || half_ff); // RL7
   assign tick_out = tick_ff;

   // ==========
   // Oscillator synchroniser; stages two and three must agree
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_ff   <= 1'b0;
         sync2_ff   <= 1'b0;
         sync3_ff   <= 1'b0;
         osc_lvl_ff <= 1'b0;
      end else begin
         sync1_ff <= osc_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         if (sync2_ff == sync3_ff) begin
            osc_lvl_ff <= sync3_ff;
         end
      end
   end

   // ==========
   // Halving toggle and prescale counter; cleared when stopped for a clean restart
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         half_ff    <= 1'b0;
         pre_cnt_ff <= 12'h000;
         tick_ff    <= 1'b0;
      end else begin
         tick_ff <= 1'b0;
         if (!run_in) begin
            half_ff    <= 1'b0;
            pre_cnt_ff <= 12'h000;
         end else begin
            if (osc_rise) begin
               half_ff <= !half_ff; // RL7
            end
            if (src_edge) begin
               if (pre_cnt_ff >= limit) begin
                  pre_cnt_ff <= 12'h000;
                  tick_ff    <= 1'b1; // RL5
               end else begin
                  pre_cnt_ff <= pre_cnt_ff + 12'h001;
               end
            end
         end
      end
   end

endmodule // wwdt_prescaler

// >>> verif/wwdt_monitor.sv
// Checker of handshakes and outcomes
`timescale 1ns/1ns
module wwdt_monitor (
   // Clock and reset
   input wire logic        MCLK_IN,
   input wire logic        RST_N_IN,
   // Write channels
   input wire logic        S_AXI_AWVALID_IN,
   input wire logic        S_AXI_AWREADY_OUT,
   input wire logic        S_AXI_WVALID_IN,
   input wire logic        S_AXI_WREADY_OUT,
   input wire logic        S_AXI_BVALID_OUT,
   // Read channels
   input wire logic        S_AXI_ARVALID_IN,
   input wire logic        S_AXI_ARREADY_OUT,
   input wire logic [31:0] S_AXI_RDATA_OUT,
   input wire logic        S_AXI_RVALID_OUT,
   input wire logic        S_AXI_RREADY_IN,
   // Watchdog outcomes
   input wire logic        WDT_RESET_REQ_OUT,
   input wire logic        WDT_IRQ_OUT
);
   // ==========
   // Nothing judged in reset
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);

   // Write taken, then answered
   sequence s_wr_taken;
      S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
   endsequence
   sequence s_wr_answer;
      ##[1:2] S_AXI_BVALID_OUT;
   endsequence

   // ==========
   // Properties
   chk_write_answer: assert property (s_wr_taken |-> s_wr_answer)
      else $error("write response missing");
   chk_write_blocked: assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
      else $error("write accepted while response pending");
   chk_read_answer: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
      else $error("read data late");
   chk_read_blocked: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
      else $error("read accepted while data pending");
   chk_rdata_upper: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   chk_rdata_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
                                    |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
      else $error("read data dropped before taken");
   chk_reset_pulse: assert property (WDT_RESET_REQ_OUT |=> !WDT_RESET_REQ_OUT)
      else $error("reset request longer than one cycle");
   chk_irq_no_reset: assert property (WDT_IRQ_OUT |-> !WDT_RESET_REQ_OUT)
      else $error("reset request in interrupt mode");
endmodule // wwdt_monitor

// >>> verif/wwdt_core_model.sv
// Processor core taking watchdog outcomes
`timescale 1ns/1ns
module wwdt_core_model (
   // Clock
   input wire logic clk_in,
   // Watchdog outcomes
   input wire logic reset_req_in,
   input wire logic irq_in,
   // Observations
   output int       resets_out,
   output logic     irq_seen_out
);
   // ==========
   // Survives system reset
   initial resets_out = 0;
   initial irq_seen_out = 1'b0;

   // One pulse, one reset
   always @(posedge clk_in) begin
      if (reset_req_in) begin
         resets_out <= resets_out + 1;
      end
      if (irq_in) begin
         irq_seen_out <= 1'b1;
      end
   end
endmodule // wwdt_core_model

// >>> verif/wwdt_top_bench.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ns
`include "wwdt_defines.vh"
module wwdt_top_bench;
   // ==========
   // Signals
   logic        clk, rst_n, dbg, hib, awvalid, wvalid, bready, arvalid, rready;
   logic        osc = 1'b0;
   logic [5:0]  osc_div = 6'h00;
   logic [31:0] awaddr, wdata, araddr, d, e;
   logic [1:0]  r;
   wire         awready, wready, bvalid, arready, rvalid, rreq, irq, irq_seen;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   int          errors, checks, nres, b, n;
   int          cyc = 0;

   wwdt_top i_wwdt_top (.MCLK_IN(clk), .RST_N_IN(rst_n), .LFOSC_IN(osc), .DEBUG_HALT_IN(dbg),
      .HIBERNATE_IN(hib), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWPROT_IN(3'h0), .S_AXI_AWVALID_IN(awvalid),
      .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'h3), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
      .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARPROT_IN(3'h0),
      .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
      .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
      .WDT_RESET_REQ_OUT(rreq), .WDT_IRQ_OUT(irq));
   wwdt_core_model i_wwdt_core_model (.clk_in(clk), .reset_req_in(rreq), .irq_in(irq),
      .resets_out(nres), .irq_seen_out(irq_seen));

   // ==========
   // Clock, 320 ns oscillator and hang guard
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      osc_div <= (osc_div == 6'd19) ? 6'd0 : osc_div + 6'd1;
      if (osc_div == 6'd19) osc <= ~osc;
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         errors++;
         tally_and_finish;
      end
   end

   // ==========
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic do_reset;
      rst_n <= 1'b0;
      dbg <= 1'b0;
      hib <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask
   // Each channel held until its handshake
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      do begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tb);
      bready <= 1'b0;
   endtask
   // Late ready: read data must stand
   task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      logic tv;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge clk);
         tv = arvalid && arready;
         @(posedge clk);
         if (tv) arvalid <= 1'b0;
      end while (!tv);
      do begin
         @(negedge clk);
         tv = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (!tv) rready <= rvalid;
      end while (!tv);
      rready <= 1'b0;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      rd(a, d, r);
      check(d, exp);
   endtask
   task automatic wait_res(input int base, input int lim, output int n);
      n = 0;
      while (nres == base && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask

   // ==========
   // Scenarios
   task automatic t_defaults;
      do_reset;
      rchk(`WWDT_ADDR_LOAD, 32'h1000);
      rchk(`WWDT_ADDR_CTRL, 32'h00c9);
      rchk(`WWDT_ADDR_MINLOAD, 32'h0800);
      rchk(`WWDT_ADDR_STATUS, 32'h0000);
      wr(`WWDT_ADDR_COUNT, 32'h1234);
      rchk(`WWDT_ADDR_COUNT, 32'h1000);
      rd(32'h400c0910, d, r);
      check({30'h0, r}, {30'h0, `WWDT_RESP_SLVERR});
      wr(32'h400c0910, 32'h0);
      check({30'h0, bresp}, {30'h0, `WWDT_RESP_SLVERR});
   endtask
   task automatic t_badkey;
      do_reset;
      b = nres;
      wr(`WWDT_ADDR_REFRESH, 32'hcccd);
      wait_res(b, 8, n);
      check(n < 8, 1);
      rchk(`WWDT_ADDR_STATUS, 32'h0004);
   endtask
   // Step spacing, then lock
   task automatic t_timing;
      logic [15:0] ctl[4] = '{16'h0060, 16'h0160, 16'h0064, 16'h0068};
      int ld[4] = '{2, 2, 2, 1};
      int lo[4] = '{80, 160, 1280, 10240};
      int hi[4] = '{150, 270, 1960, 20520};
      for (int i = 0; i < 4; i++) begin
         do_reset;
         wr(`WWDT_ADDR_LOAD, ld[i]);
         b = nres;
         wr(`WWDT_ADDR_CTRL, {16'h0, ctl[i]});
         wait_res(b, 30000, n);
         check(n >= lo[i] && n <= hi[i], 1);
         wr(`WWDT_ADDR_LOAD, 32'h0005);
         wr(`WWDT_ADDR_CTRL, 32'h0000);
         rchk(`WWDT_ADDR_LOAD, ld[i]);
         rchk(`WWDT_ADDR_CTRL, {16'h0, ctl[i] | 16'h0080});
      end
   endtask
   task automatic t_refresh;
      do_reset;
      wr(`WWDT_ADDR_LOAD, 32'h0050);
      wr(`WWDT_ADDR_CTRL, 32'h0060);
      repeat (200) @(posedge clk);
      b = nres;
      rd(`WWDT_ADDR_COUNT, d, r);
      check(d < 32'h0050, 1);
      wr(`WWDT_ADDR_REFRESH, 32'hcccc);
      rd(`WWDT_ADDR_COUNT, d, r);
      check(d >= 32'h004e, 1);
      check(nres - b, 0);
      // Free-running wrap
      do_reset;
      wr(`WWDT_ADDR_LOAD, 32'h0002);
      b = nres;
      wr(`WWDT_ADDR_CTRL, 32'h0020);
      wait_res(b, 200, n);
      rd(`WWDT_ADDR_COUNT, d, r);
      check(n < 200 && d >= 32'h0ff0 && d <= 32'h1000, 1);
   endtask
   task automatic t_irq;
      do_reset;
      hib <= 1'b1;
      wr(`WWDT_ADDR_LOAD, 32'h0100);
      wr(`WWDT_ADDR_MINLOAD, 32'h0080);
      b = nres;
      wr(`WWDT_ADDR_CTRL, 32'h0661);
      wr(`WWDT_ADDR_REFRESH, 32'hcccc);
      @(posedge clk);
      check(irq, 1);
      rchk(`WWDT_ADDR_STATUS, 32'h001a);
      rd(`WWDT_ADDR_COUNT, d, r);
      repeat (200) @(posedge clk);
      rd(`WWDT_ADDR_COUNT, e, r);
      check(e < d, 1);
      check(nres - b, 0);
      check(irq_seen, 1);
   endtask
   task automatic t_halt;
      for (int i = 0; i < 2; i++) begin
         do_reset;
         wr(`WWDT_ADDR_LOAD, 32'h0100);
         wr(`WWDT_ADDR_CTRL, 32'h0061);
         dbg <= (i == 0);
         hib <= (i == 1);
         repeat (10) @(posedge clk);
         rd(`WWDT_ADDR_COUNT, d, r);
         repeat (200) @(posedge clk);
         rd(`WWDT_ADDR_COUNT, e, r);
         check(e, d);
      end
   endtask

   // ==========
   // Verdict and main sequence
   task automatic tally_and_finish;
      if (errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      {rst_n, dbg, hib, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
      {awaddr, wdata, araddr} = 96'h0;
      errors = 0;
      checks = 0;
      t_defaults;
      t_badkey;
      t_timing;
      t_refresh;
      t_irq;
      t_halt;
      tally_and_finish;
   end
endmodule // wwdt_top_bench

bind wwdt_top wwdt_monitor i_wwdt_monitor (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
   .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN), .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT),
   .S_AXI_WVALID_IN(S_AXI_WVALID_IN), .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
   .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
   .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
   .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
   .WDT_RESET_REQ_OUT(WDT_RESET_REQ_OUT), .WDT_IRQ_OUT(WDT_IRQ_OUT));
